// [rtl/psq_consts.svh]
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PSQ_OFF_GEN_CTRL 8'h00
`define PSQ_OFF_WAKE_LOW 8'h04
`define PSQ_OFF_WAKE_HIGH 8'h08
`define PSQ_OFF_ASLEEP 8'h0C
`define PSQ_OFF_WAKE_ONE 8'h10
`define PSQ_OFF_WAKE_TWO 8'h14

// ----------------------------------------------------------------------------
// general control fields
// ----------------------------------------------------------------------------
`define PSQ_GC_PIN_EN 2
`define PSQ_GC_PIN_POL 3
`define PSQ_GC_TMR_EN 4
`define PSQ_GC_TMR64 5
`define PSQ_GC_MASK 32'h0000_003C
`define PSQ_GC_RST 32'h0000_0008

// ----------------------------------------------------------------------------
// supply configuration fields
// ----------------------------------------------------------------------------
`define PSQ_CF_DWELL_LSB 16
`define PSQ_CF_DWELL_MSB 20
`define PSQ_CF_TILE_GATE 14
`define PSQ_CF_ANA_PFM 9
`define PSQ_CF_CORE_PFM 8
`define PSQ_CF_IO_EN 5
`define PSQ_CF_PLL_EN 4
`define PSQ_CF_ANA_EN 1
`define PSQ_CF_CORE_EN 0
`define PSQ_CF_RW_MASK 32'h001F_4331

// ----------------------------------------------------------------------------
// reset values (dwell field added separately)
// ----------------------------------------------------------------------------
`define PSQ_DWELL_RST 16
`define PSQ_ASLEEP_RST 32'h0000_0000
`define PSQ_WAKE_ONE_RST 32'h0000_0020
`define PSQ_WAKE_TWO_RST 32'h0000_0031
`define PSQ_ASLEEP_ANA 1'h0
`define PSQ_WAKE_ONE_ANA 1'h0
`define PSQ_WAKE_TWO_ANA 1'h1

`endif

// [rtl/psq_pin_sync.sv]
`default_nettype none
module psq_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic core_clk, // sequencer clock
  input wire logic rst_b, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // pins from outside this clock domain
  output logic [WIDTH-1:0] sync_out // filtered level
);
  import psq_pkg::*;

  // --------------------------------------------------------------------------
  // three-stage capture, accepted once stages two and three agree
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } psq_sync_s;

  psq_sync_s q;
  psq_sync_s next_q;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1 || WIDTH > 32) begin : g_chk
    $error("psq_pin_sync: WIDTH must be 1 to 32");
  end

  always_comb begin
    next_q = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    next_q.level = (q.s3 & agree) | (q.level & ~agree);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{s1: RST_VAL[WIDTH-1:0], s2: RST_VAL[WIDTH-1:0],
             s3: RST_VAL[WIDTH-1:0], level: RST_VAL[WIDTH-1:0]};
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.level;

endmodule : psq_pin_sync
`default_nettype wire

// [rtl/psq_pkg.sv]
`default_nettype none
package psq_pkg;

  typedef enum logic [1:0] {
    PSQ_AWAKE,
    PSQ_ASLEEP,
    PSQ_WAKE_ONE,
    PSQ_WAKE_TWO
  } psq_state_e;

  typedef logic [31:0] psq_word_t;

endpackage : psq_pkg
`default_nettype wire

// [rtl/psq_sleep_wake_seq.sv]
// What this block does
// - low wake time is compared with the counter only when timer wake is on and asleep
// - upper wake word is ignored unless 64-bit comparison is selected
// - asleep leaves after the dwell once timer or wake pin condition occurs
// - asleep dwell counts cycles of whichever clock currently runs the block
// - both waking states leave after the dwell only when enabled supplies are good
// - dwell field bits 20:16 gives two to that power cycles, reset 16
// - bit 14 gates the processor tile clock while in that state
// - bit 9 picks analog buck modulation, 0 pwm, 1 pfm
// - bit 8 picks core buck modulation, 0 pwm, 1 pfm
// - bit 5 enables the io supply, reset 0 asleep, 1 waking
// - bit 4 enables the pll regulator, reset 1 only in phase two
// - bit 1 is read-only analog enable, 1 only in phase two
// - bit 0 enables the core buck, reset 1 only in phase two
// - a state's settings are applied for as long as the state lasts
// - a control bit enables wake on timer comparison
// - a control bit selects 64-bit timer comparison
// - a control bit enables wake on the wake pin level
// - polarity bit, reset 1, selects high level wake, 0 low level
`include "psq_consts.svh"
`default_nettype none
module psq_sleep_wake_seq #(
  parameter int unsigned DWELL_RST_EXP = `PSQ_DWELL_RST
) (
  input wire logic core_clk, // selected sleep clock, 100 MHz nominal
  input wire logic rst_b, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register byte offset
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data, valid with reg_rvalid
  output logic reg_rvalid, // one-cycle read answer
  input wire logic [63:0] rtc_count, // real-time counter, same clock
  input wire logic sleep_enter, // pulse from awake side: enter asleep
  input wire psq_pkg::psq_word_t awake_cfg, // supply settings used while awake
  input wire logic wake_pin, // external wake pin, asynchronous
  input wire logic core_buck_good, // core buck power good
  input wire logic analog_buck_good, // analog buck power good
  input wire logic pll_ldo_good, // pll regulator power good
  input wire logic io_supply_good, // io supply power good
  output psq_pkg::psq_state_e seq_state, // current sequencer state
  output logic wake_done, // pulse on return to awake
  output logic tile_clk_gate, // 1 stops the processor tile clock
  output logic analog_buck_pfm, // analog buck modulation, 1 pfm
  output logic core_buck_pfm, // core buck modulation, 1 pfm
  output logic io_supply_en, // io supply output enable
  output logic pll_ldo_en, // pll linear regulator enable
  output logic analog_buck_en, // analog buck enable
  output logic core_buck_en // core buck enable
);
  import psq_pkg::*;

  // --------------------------------------------------------------------------
  // state and constants
  // --------------------------------------------------------------------------
  typedef struct packed {
    psq_state_e state;
    logic [31:0] gen_ctrl;
    logic [31:0] wake_lo;
    logic [31:0] wake_hi;
    logic [2:0][31:0] cfg;
    logic [31:0] dwell_cnt;
    logic timer_hit;
    logic [31:0] rdata;
    logic rvalid;
    logic done;
    logic [6:0] drive;
  } psq_main_s;

  localparam logic [31:0] DWELL_FIELD = {11'h000, DWELL_RST_EXP[4:0], 16'h0000};

  if (DWELL_RST_EXP > 31) begin : g_chk
    $error("psq_sleep_wake_seq: DWELL_RST_EXP must be 0 to 31");
  end

  psq_main_s q;
  psq_main_s next_q;
  logic [3:0] good_sync;
  logic wake_sync;
  logic tmr_match;
  logic pin_hit;
  logic dwell_done;
  logic supplies_ok;
  logic [31:0] apply_word;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  psq_pin_sync #(.WIDTH(4), .RST_VAL(32'h0000_0000)) u_good_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({io_supply_good, pll_ldo_good, analog_buck_good, core_buck_good}),
    .sync_out(good_sync)
  );

  psq_pin_sync #(.WIDTH(1), .RST_VAL(32'h0000_0000)) u_wake_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(wake_pin),
    .sync_out(wake_sync)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [1:0] cfg_index(input psq_state_e st);
    case (st)
      PSQ_WAKE_ONE: cfg_index = 2'h1;
      PSQ_WAKE_TWO: cfg_index = 2'h2;
      default: cfg_index = 2'h0;
    endcase
  endfunction : cfg_index

  // stored word plus the per-state read-only analog enable
  function automatic logic [31:0] cfg_view(input logic [31:0] raw, input logic [1:0] idx);
    logic ana;
    ana = (idx == 2'h2) ? `PSQ_WAKE_TWO_ANA :
          (idx == 2'h1) ? `PSQ_WAKE_ONE_ANA : `PSQ_ASLEEP_ANA;
    cfg_view = (raw & `PSQ_CF_RW_MASK) | {30'h0000_0000, ana, 1'h0};
  endfunction : cfg_view

  // last count of a minimum stay of two to the power exp cycles
  function automatic logic [31:0] dwell_limit(input logic [4:0] exp);
    dwell_limit = (32'h0000_0001 << exp) - 32'h0000_0001;
  endfunction : dwell_limit

  // --------------------------------------------------------------------------
  // conditions
  // --------------------------------------------------------------------------
  always_comb begin
    // a compare can only matter while asleep with timer wake on
    tmr_match = q.gen_ctrl[`PSQ_GC_TMR_EN] && (q.state == PSQ_ASLEEP) &&
                (rtc_count[31:0] == q.wake_lo) &&
                (!q.gen_ctrl[`PSQ_GC_TMR64] || rtc_count[63:32] == q.wake_hi);
    pin_hit = q.gen_ctrl[`PSQ_GC_PIN_EN] &&
              (wake_sync == q.gen_ctrl[`PSQ_GC_PIN_POL]);
    // dwell counts core_clk, which is whatever sleep clock is selected
    dwell_done = q.dwell_cnt >= dwell_limit(q.cfg[cfg_index(q.state)][20:16]);
    // only supplies that this state enables need to report good
    supplies_ok = (!q.drive[0] || good_sync[0]) && (!q.drive[1] || good_sync[1]) &&
                  (!q.drive[2] || good_sync[2]) && (!q.drive[3] || good_sync[3]);
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.rvalid = 1'h0;
    next_q.done = 1'h0;
    apply_word = 32'h0000_0000;

    if (reg_wr) begin
      case (reg_addr)
        `PSQ_OFF_GEN_CTRL: next_q.gen_ctrl = reg_wdata & `PSQ_GC_MASK;
        `PSQ_OFF_WAKE_LOW: next_q.wake_lo = reg_wdata;
        `PSQ_OFF_WAKE_HIGH: next_q.wake_hi = reg_wdata;
        `PSQ_OFF_ASLEEP: next_q.cfg[0] = reg_wdata & `PSQ_CF_RW_MASK;
        `PSQ_OFF_WAKE_ONE: next_q.cfg[1] = reg_wdata & `PSQ_CF_RW_MASK;
        `PSQ_OFF_WAKE_TWO: next_q.cfg[2] = reg_wdata & `PSQ_CF_RW_MASK;
        default: ;
      endcase
    end

    if (reg_rd) begin
      next_q.rvalid = 1'h1;
      case (reg_addr)
        `PSQ_OFF_GEN_CTRL: next_q.rdata = q.gen_ctrl;
        `PSQ_OFF_WAKE_LOW: next_q.rdata = q.wake_lo;
        `PSQ_OFF_WAKE_HIGH: next_q.rdata = q.wake_hi;
        `PSQ_OFF_ASLEEP: next_q.rdata = cfg_view(q.cfg[0], 2'h0);
        `PSQ_OFF_WAKE_ONE: next_q.rdata = cfg_view(q.cfg[1], 2'h1);
        `PSQ_OFF_WAKE_TWO: next_q.rdata = cfg_view(q.cfg[2], 2'h2);
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // the timer match is a single-cycle event, so it is held until the dwell ends
    if (tmr_match) begin
      next_q.timer_hit = 1'h1;
    end
    if (!dwell_done) begin
      next_q.dwell_cnt = q.dwell_cnt + 32'h0000_0001;
    end

    case (q.state)
      PSQ_AWAKE: begin
        if (sleep_enter) begin
          next_q.state = PSQ_ASLEEP;
        end
      end
      PSQ_ASLEEP: begin
        if (dwell_done && (q.timer_hit || tmr_match || pin_hit)) begin
          next_q.state = PSQ_WAKE_ONE;
        end
      end
      PSQ_WAKE_ONE: begin
        if (dwell_done && supplies_ok) begin
          next_q.state = PSQ_WAKE_TWO;
        end
      end
      PSQ_WAKE_TWO: begin
        if (dwell_done && supplies_ok) begin
          next_q.state = PSQ_AWAKE;
          next_q.done = 1'h1;
        end
      end
      default: next_q.state = PSQ_AWAKE;
    endcase

    if (next_q.state != q.state) begin
      next_q.dwell_cnt = 32'h0000_0000;
      next_q.timer_hit = 1'h0;
    end

    // settings follow the state being entered, and later writes apply at once
    if (next_q.state == PSQ_AWAKE) begin
      apply_word = awake_cfg;
    end else begin
      apply_word = cfg_view(next_q.cfg[cfg_index(next_q.state)],
                            cfg_index(next_q.state));
    end
    next_q.drive = {apply_word[`PSQ_CF_TILE_GATE],
                    apply_word[`PSQ_CF_ANA_PFM],
                    apply_word[`PSQ_CF_CORE_PFM],
                    apply_word[`PSQ_CF_IO_EN],
                    apply_word[`PSQ_CF_PLL_EN],
                    apply_word[`PSQ_CF_ANA_EN],
                    apply_word[`PSQ_CF_CORE_EN]};
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q.state <= PSQ_AWAKE;
      q.gen_ctrl <= `PSQ_GC_RST;
      q.wake_lo <= 32'h0000_0000;
      q.wake_hi <= 32'h0000_0000;
      q.cfg[0] <= `PSQ_ASLEEP_RST | DWELL_FIELD;
      q.cfg[1] <= `PSQ_WAKE_ONE_RST | DWELL_FIELD;
      q.cfg[2] <= `PSQ_WAKE_TWO_RST | DWELL_FIELD;
      q.dwell_cnt <= 32'h0000_0000;
      q.timer_hit <= 1'h0;
      q.rdata <= 32'h0000_0000;
      q.rvalid <= 1'h0;
      q.done <= 1'h0;
      q.drive <= 7'h00;
    end else begin
      q <= next_q;
    end
  end

  assign seq_state = q.state;
  assign wake_done = q.done;
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign tile_clk_gate = q.drive[6];
  assign analog_buck_pfm = q.drive[5];
  assign core_buck_pfm = q.drive[4];
  assign io_supply_en = q.drive[3];
  assign pll_ldo_en = q.drive[2];
  assign analog_buck_en = q.drive[1];
  assign core_buck_en = q.drive[0];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_leave_asleep;
    $past(q.state) == PSQ_ASLEEP && q.state == PSQ_WAKE_ONE;
  endsequence
  sequence s_leave_one;
    $past(q.state) == PSQ_WAKE_ONE && q.state == PSQ_WAKE_TWO;
  endsequence
  sequence s_leave_two;
    $past(q.state) == PSQ_WAKE_TWO && q.state == PSQ_AWAKE;
  endsequence

  a_asleep_dwell_cause: assert property (
    s_leave_asleep |-> $past(dwell_done) && $past(q.timer_hit || tmr_match || pin_hit))
    else $error("asleep left before dwell or without a wake cause");

  a_phase_one_good: assert property (
    s_leave_one |-> $past(dwell_done) && $past(supplies_ok))
    else $error("phase one left without dwell or power good");

  a_phase_two_done: assert property (
    s_leave_two |-> wake_done && $past(supplies_ok) && $past(dwell_done))
    else $error("phase two exit not gated or not reported");

  a_dwell_zero_min: assert property (
    ($changed(q.state) && q.state != PSQ_AWAKE && q.cfg[cfg_index(q.state)][20:16] != 5'h00)
    |=> q.state == $past(q.state))
    else $error("state left before two cycles with non-zero dwell field");

  a_timer_low_only: assert property (
    (q.state == PSQ_ASLEEP && q.gen_ctrl[`PSQ_GC_TMR_EN] && !q.gen_ctrl[`PSQ_GC_TMR64]
     && rtc_count[31:0] == q.wake_lo) |=> q.timer_hit || q.state == PSQ_WAKE_ONE)
    else $error("low word match ignored in 32-bit mode");

  a_timer_disabled: assert property (
    (q.state == PSQ_ASLEEP && !q.gen_ctrl[`PSQ_GC_TMR_EN] && !q.timer_hit
     && $stable(q.gen_ctrl)) |=> !q.timer_hit)
    else $error("timer wake recorded while disabled");

  a_pin_wakes: assert property (
    (q.state == PSQ_ASLEEP && dwell_done && pin_hit) |=> q.state == PSQ_WAKE_ONE)
    else $error("wake pin level did not start waking");

  a_settings_held: assert property (
    (q.state == PSQ_WAKE_ONE && $stable(q.state) && $stable(q.cfg[1]))
    |-> io_supply_en == q.cfg[1][`PSQ_CF_IO_EN] && tile_clk_gate == q.cfg[1][`PSQ_CF_TILE_GATE]
        && core_buck_en == q.cfg[1][`PSQ_CF_CORE_EN] && !analog_buck_en)
    else $error("phase one outputs differ from its settings");

  a_reserved_zero: assert property (
    (reg_rd && reg_addr inside {`PSQ_OFF_ASLEEP, `PSQ_OFF_WAKE_ONE, `PSQ_OFF_WAKE_TWO})
    |=> reg_rvalid && (reg_rdata & ~(`PSQ_CF_RW_MASK | 32'h0000_0002)) == 32'h0000_0000)
    else $error("reserved configuration bits read non-zero");

  a_analog_fixed: assert property (
    (reg_rd && reg_addr == `PSQ_OFF_WAKE_TWO) ##1 1'b1 |-> reg_rdata[`PSQ_CF_ANA_EN])
    else $error("phase two analog enable not read as one");

  a_sleep_entry: assert property (
    (q.state == PSQ_AWAKE && sleep_enter) |=> q.state == PSQ_ASLEEP)
    else $error("sleep request did not enter asleep");

  a_timer_high_word: assert property (
    (q.state == PSQ_ASLEEP && q.gen_ctrl[`PSQ_GC_TMR64] && !q.timer_hit
     && rtc_count[63:32] != q.wake_hi) |=> !q.timer_hit)
    else $error("timer wake recorded with high word unequal");

  a_phase_two_drive: assert property (
    (q.state == PSQ_WAKE_TWO && $stable(q.state) && $stable(q.cfg[2]))
    |-> core_buck_en == q.cfg[2][`PSQ_CF_CORE_EN] && pll_ldo_en == q.cfg[2][`PSQ_CF_PLL_EN]
        && analog_buck_en)
    else $error("phase two outputs differ from its settings");

endmodule : psq_sleep_wake_seq
`default_nettype wire

// [tb/psq_supply_model.sv]
`default_nettype none
// ----------------------------------------------------------------------------
// regulator models: power-good follows enable after a settling delay
// ----------------------------------------------------------------------------
module psq_supply_model #(
  parameter int unsigned DELAY = 6
) (
  input wire logic core_clk, // sequencer clock
  input wire logic rst_b, // async reset, active low
  input wire logic core_buck_en, // core buck enable
  input wire logic analog_buck_en, // analog buck enable
  input wire logic pll_ldo_en, // pll regulator enable
  input wire logic io_supply_en, // io supply enable
  input wire logic hold_io_bad, // forces a stuck io supply fault
  output logic core_buck_good, // core buck good
  output logic analog_buck_good, // analog buck good
  output logic pll_ldo_good, // pll regulator good
  output logic io_supply_good // io supply good
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] en;
  logic [7:0] cnt [4];

  assign en = {io_supply_en, pll_ldo_en, analog_buck_en, core_buck_en};

  // a disabled regulator drops good at once, as the pull-down would
  always_ff @(posedge core_clk or negedge rst_b) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b || !en[i]) begin
        cnt[i] <= 8'h00;
      end else if (cnt[i] < 8'(DELAY)) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end

  assign core_buck_good = en[0] && (cnt[0] >= 8'(DELAY));
  assign analog_buck_good = en[1] && (cnt[1] >= 8'(DELAY));
  assign pll_ldo_good = en[2] && (cnt[2] >= 8'(DELAY));
  assign io_supply_good = en[3] && (cnt[3] >= 8'(DELAY)) && !hold_io_bad;
endmodule : psq_supply_model
`default_nettype wire

// [tb/tb_sleep_wake_power_sequencer.sv]
`include "psq_consts.svh"
`default_nettype none
module tb_sleep_wake_power_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import psq_pkg::*;
  localparam int DW = 2;
  localparam psq_word_t AWAKE_CFG = 32'h0000_0033;
  localparam psq_word_t ASL = 32'h0003_4300;
  localparam psq_word_t OMASK = 32'h0000_4333;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [63:0] rtc_count = 64'h0;
  logic sleep_enter = 1'b0;
  logic wake_pin = 1'b1;
  logic hold_io_bad = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rvalid, wake_done, tile_clk_gate, analog_buck_pfm, core_buck_pfm;
  logic io_supply_en, pll_ldo_en, analog_buck_en, core_buck_en;
  logic core_buck_good, analog_buck_good, pll_ldo_good, io_supply_good;
  psq_state_e seq_state;
  logic [31:0] outs;
  int err_count = 0;
  int comparisons = 0;

  assign outs = {17'h0, tile_clk_gate, 4'h0, analog_buck_pfm, core_buck_pfm, 2'h0,
                 io_supply_en, pll_ldo_en, 2'h0, analog_buck_en, core_buck_en};

  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) rtc_count <= rtc_count + 64'h1;

  psq_sleep_wake_seq #(.DWELL_RST_EXP(DW)) i_psq_sleep_wake_seq (
    .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rtc_count(rtc_count), .sleep_enter(sleep_enter),
    .awake_cfg(AWAKE_CFG), .wake_pin(wake_pin), .core_buck_good(core_buck_good),
    .analog_buck_good(analog_buck_good), .pll_ldo_good(pll_ldo_good),
    .io_supply_good(io_supply_good), .seq_state(seq_state), .wake_done(wake_done),
    .tile_clk_gate(tile_clk_gate), .analog_buck_pfm(analog_buck_pfm),
    .core_buck_pfm(core_buck_pfm), .io_supply_en(io_supply_en), .pll_ldo_en(pll_ldo_en),
    .analog_buck_en(analog_buck_en), .core_buck_en(core_buck_en));

  psq_supply_model #(.DELAY(6)) i_psq_supply_model (
    .core_clk(core_clk), .rst_b(rst_b), .core_buck_en(core_buck_en),
    .analog_buck_en(analog_buck_en), .pll_ldo_en(pll_ldo_en), .io_supply_en(io_supply_en),
    .hold_io_bad(hold_io_bad), .core_buck_good(core_buck_good),
    .analog_buck_good(analog_buck_good), .pll_ldo_good(pll_ldo_good),
    .io_supply_good(io_supply_good));

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  // a missing rvalid turns the data into a sure mismatch
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(what, (reg_rvalid === 1'b1) ? reg_rdata : ~exp, exp);
  endtask : rd_chk

  task automatic wait_st(input psq_state_e s, input int lim, output int n);
    n = 0;
    while (seq_state !== s && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) chk("state reached", {30'h0, seq_state}, {30'h0, s});
  endtask : wait_st

  task automatic sleep_now();
    @(negedge core_clk);
    sleep_enter = 1'b1;
    @(negedge core_clk);
    sleep_enter = 1'b0;
  endtask : sleep_now

  task automatic finish_wake();
    int n;
    wait_st(PSQ_WAKE_ONE, 300, n);
    chk("phase one outputs", outs, 32'h0000_0020);
    wait_st(PSQ_WAKE_TWO, 300, n);
    chk("phase two outputs", outs, 32'h0000_0033);
    wait_st(PSQ_AWAKE, 300, n);
    chk("wake done", {31'h0, wake_done}, 32'h1);
    @(negedge core_clk);
    chk("wake done end", {31'h0, wake_done}, 32'h0);
    chk("awake outputs", outs, AWAKE_CFG & OMASK);
  endtask : finish_wake

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    chk("awake after reset", {30'h0, seq_state}, {30'h0, PSQ_AWAKE});
    chk("awake reset outputs", outs, AWAKE_CFG & OMASK);
    rd_chk(8'h00, 32'h0000_0008, "ctrl reset");
    rd_chk(8'h04, 32'h0, "wake low reset");
    rd_chk(8'h08, 32'h0, "wake high reset");
    rd_chk(8'h0C, (DW << 16), "asleep reset");
    rd_chk(8'h10, (DW << 16) | 32'h20, "phase one reset");
    rd_chk(8'h14, (DW << 16) | 32'h33, "phase two reset");
    rd_chk(8'h30, 32'h0, "unmapped read");
  endtask : t_reset

  task automatic t_reserved();
    wr(8'h0C, 32'hFFFF_FFFF);
    rd_chk(8'h0C, 32'h001F_4331, "asleep all ones");
    wr(8'h14, 32'h0);
    rd_chk(8'h14, 32'h0000_0002, "phase two zeros");
    wr(8'h0C, ASL);
    wr(8'h14, (DW << 16) | 32'h31);
  endtask : t_reserved

  task automatic t_pin_wake();
    int n;
    wr(8'h00, 32'h0000_000C);
    sleep_now();
    chk("asleep outputs", outs, ASL & OMASK);
    wait_st(PSQ_WAKE_ONE, 100, n);
    chk("asleep dwell", n, 32'd8);
    finish_wake();
  endtask : t_pin_wake

  task automatic t_timer();
    int n;
    logic [31:0] tgt;
    wr(8'h00, 32'h0000_0010);
    wr(8'h08, 32'h0000_0005);
    tgt = rtc_count[31:0] + 32'd60;
    wr(8'h04, tgt);
    sleep_now();
    wait_st(PSQ_WAKE_ONE, 200, n);
    chk("timer wake moment", {31'h0, (rtc_count[31:0] - tgt) < 32'h4}, 32'h1);
    finish_wake();
    wr(8'h00, 32'h0000_0030);
    tgt = rtc_count[31:0] + 32'd60;
    wr(8'h04, tgt);
    sleep_now();
    repeat (120) @(negedge core_clk);
    chk("high word mismatch", {30'h0, seq_state}, {30'h0, PSQ_ASLEEP});
    wr(8'h00, 32'h0000_0034);
    repeat (40) @(negedge core_clk);
    chk("pin wrong level", {30'h0, seq_state}, {30'h0, PSQ_ASLEEP});
    wake_pin = 1'b0;
    wait_st(PSQ_WAKE_ONE, 20, n);
    chk("low level wake", {31'h0, n < 20}, 32'h1);
    finish_wake();
    wake_pin = 1'b1;
  endtask : t_timer

  task automatic t_goods();
    int n;
    wr(8'h00, 32'h0000_000C);
    hold_io_bad = 1'b1;
    sleep_now();
    wait_st(PSQ_WAKE_ONE, 100, n);
    repeat (60) @(negedge core_clk);
    chk("held by bad supply", {30'h0, seq_state}, {30'h0, PSQ_WAKE_ONE});
    hold_io_bad = 1'b0;
    finish_wake();
  endtask : t_goods

  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // the whole run needs some five hundred cycles; this allows ample slack
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_reserved();
    t_pin_wake();
    t_timer();
    t_goods();
    tally_and_finish();
  end
endmodule : tb_sleep_wake_power_sequencer
`default_nettype wire
